// >>> shared/shps_pkg.sv
// Constants for the serial host port pin multiplexer.
// Assumes a single core clock; all pin inputs already synchronous to it.
package shps_pkg;

	localparam logic SHPS_SEL_SPI       = 1'b0;
	localparam logic SHPS_SEL_I2C       = 1'b1;
	localparam logic SHPS_RST_MODE      = 1'b0;
	localparam logic SHPS_RST_SO        = 1'b0;
	localparam logic SHPS_RST_OE        = 1'b0;
	localparam logic SHPS_RST_INT_OE    = 1'b0;
	localparam logic SHPS_RST_ADDR_BIT0 = 1'b0;

	typedef enum logic [1:0] {
		SHPS_ST_IDLE,
		SHPS_ST_SPI,
		SHPS_ST_I2C
	} shps_state_type;

endpackage : shps_pkg

// >>> verilog/shps_edge_det.sv
// Registered copy and rising/falling edge detector for one synchronous input.
// Assumes the input is already synchronous to core_clk_in.
`timescale 1ns/1ps
module shps_edge_det
	import shps_pkg::*;
(
	input  wire logic core_clk_in,  // Core clock
	input  wire logic resetn_in,    // Synchronous reset, active low
	input  wire logic sig_in,       // Sampled level
	output logic      level_out,    // Registered level
	output logic      rise_out,     // One-cycle pulse on rising edge
	output logic      fall_out      // One-cycle pulse on falling edge
);

	logic prev_q;
	logic prev_d;

	always_comb begin
		prev_d = sig_in;
	end

	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			// Load the live level so an idle-high pin gives no false edge after reset
			prev_q <= prev_d;
		end else begin
			prev_q <= prev_d;
		end
	end

	assign level_out = prev_q;
	assign rise_out  = sig_in & ~prev_q;
	assign fall_out  = ~sig_in & prev_q;

endmodule : shps_edge_det

// >>> verilog/shps_top.sv
// Pin-level multiplexer for the host configuration port. The protocol engines
// sit inside the device core and talk to this block through the core_* ports.
// All pin inputs are assumed synchronous to core_clk_in.
`timescale 1ns/1ps
module shps_top
	import shps_pkg::*;
(
	input  wire logic core_clk_in,        // Core clock, 10 MHz
	input  wire logic resetn_in,          // Synchronous reset, active low
	input  wire logic i2c_sel_in,         // Interface select strap, 1 = I2C
	input  wire logic clk_pin_in,         // Shared clock pin level
	input  wire logic data_pin_in,        // Shared data pin level
	input  wire logic sel_pin_in,         // Chip select / address bit pin
	input  wire logic core_rd_data_in,    // SPI read data bit from core
	input  wire logic core_i2c_scl_low_in,// Core wants to stretch the I2C clock
	input  wire logic core_i2c_sda_low_in,// Core wants to pull I2C data low
	input  wire logic core_status_in,     // Status change pulse from core
	input  wire logic core_int_clear_in,  // Host has read the status registers
	output logic      i2c_mode_out,       // Registered interface mode, 1 = I2C
	output logic      clk_pin_out,        // Clock pin drive level (always 0)
	output logic      clk_pin_oe_out,     // Clock pin output enable, high drives
	output logic      data_pin_out,       // Data pin drive level (always 0)
	output logic      data_pin_oe_out,    // Data pin output enable, high drives
	output logic      so_out,             // Dedicated serial data output
	output logic      spi_active_out,     // SPI frame in progress
	output logic      spi_sck_rise_out,   // Qualified SPI clock rising edge pulse
	output logic      spi_sck_fall_out,   // Qualified SPI clock falling edge pulse
	output logic      spi_mosi_out,       // SPI data input to core
	output logic      i2c_scl_out,        // Registered I2C clock line level
	output logic      i2c_sda_out,        // Registered I2C data line level
	output logic      slave_addr_bit0_out,// I2C slave address bit 0
	output logic      int_n_out,          // Interrupt drive level (always 0)
	output logic      int_oe_out          // Interrupt output enable, high pulls low
);

	shps_state_type state_q;
	shps_state_type state_d;
	logic           mode_q;
	logic           mode_d;
	logic           so_q;
	logic           so_d;
	logic           clk_oe_q;
	logic           clk_oe_d;
	logic           data_oe_q;
	logic           data_oe_d;
	logic           active_q;
	logic           active_d;
	logic           rise_q;
	logic           rise_d;
	logic           fall_q;
	logic           fall_d;
	logic           mosi_q;
	logic           mosi_d;
	logic           scl_q;
	logic           scl_d;
	logic           sda_q;
	logic           sda_d;
	logic           addr_q;
	logic           addr_d;
	logic           int_oe_q;
	logic           int_oe_d;
	logic           clk_drv_q;
	logic           clk_drv_d;
	logic           data_drv_q;
	logic           data_drv_d;
	logic           int_drv_q;
	logic           int_drv_d;
	logic           clk_rise;
	logic           clk_fall;

	// Edge detector on the shared clock pin, used only in SPI mode
	// Qualified edges reach the core one clock after the pin moves
	shps_edge_det u_clk_edge (
		.core_clk_in (core_clk_in),
		.resetn_in   (resetn_in),
		.sig_in      (clk_pin_in),
		.level_out   (),
		.rise_out    (clk_rise),
		.fall_out    (clk_fall)
	);

	always_comb begin
		state_d   = state_q;
		mode_d    = mode_q;
		so_d      = SHPS_RST_SO;
		clk_oe_d  = SHPS_RST_OE;
		data_oe_d = SHPS_RST_OE;
		active_d  = 1'b0;
		rise_d    = 1'b0;
		fall_d    = 1'b0;
		mosi_d    = 1'b0;
		scl_d     = 1'b1;
		sda_d     = 1'b1;
		addr_d    = addr_q;
		// Drive levels stay low; only the enables move on open-drain lines
		clk_drv_d  = 1'b0;
		data_drv_d = 1'b0;
		case (state_q)
			SHPS_ST_IDLE: begin
				// Strap is taken one clock after reset release, then steers the pins
				mode_d = i2c_sel_in;
				if (i2c_sel_in == SHPS_SEL_I2C) begin
					state_d = SHPS_ST_I2C;
				end else begin
					state_d = SHPS_ST_SPI;
				end
			end
			SHPS_ST_SPI: begin
				// Pins stay input only; the select pin frames each transfer
				if (!sel_pin_in) begin
					active_d = 1'b1;
					rise_d   = clk_rise;
					fall_d   = clk_fall;
					mosi_d   = data_pin_in;
					so_d     = core_rd_data_in;
				end else begin
					// Deselected: edges dropped and serial output parked low
					rise_d   = 1'b0;
					fall_d   = 1'b0;
					so_d     = SHPS_RST_SO;
				end
			end
			SHPS_ST_I2C: begin
				// Open-drain drive on both shared lines
				scl_d     = clk_pin_in;
				sda_d     = data_pin_in;
				clk_oe_d  = core_i2c_scl_low_in;
				data_oe_d = core_i2c_sda_low_in;
				// Tracked every cycle, so a board strap change shows one clock later
				addr_d    = sel_pin_in;
				so_d      = 1'b0;
			end
			default: begin
				state_d = SHPS_ST_IDLE;
			end
		endcase
	end

	// Interrupt flag and its open-drain drive level
	always_comb begin
		int_drv_d = 1'b0;
		// Set wins over clear so a change during the host read is not lost
		if (core_status_in) begin
			int_oe_d = 1'b1;
		end else if (core_int_clear_in) begin
			int_oe_d = 1'b0;
		end else begin
			int_oe_d = int_oe_q;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			int_oe_q  <= SHPS_RST_INT_OE;
			int_drv_q <= 1'b0;
		end else begin
			int_oe_q  <= int_oe_d;
			int_drv_q <= int_drv_d;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			state_q   <= SHPS_ST_IDLE;
			mode_q    <= SHPS_RST_MODE;
			so_q      <= SHPS_RST_SO;
			clk_oe_q  <= SHPS_RST_OE;
			data_oe_q <= SHPS_RST_OE;
			active_q  <= 1'b0;
			rise_q    <= 1'b0;
			fall_q    <= 1'b0;
			mosi_q    <= 1'b0;
			scl_q     <= 1'b1;
			sda_q     <= 1'b1;
			addr_q    <= SHPS_RST_ADDR_BIT0;
			clk_drv_q  <= 1'b0;
			data_drv_q <= 1'b0;
		end else begin
			state_q   <= state_d;
			mode_q    <= mode_d;
			so_q      <= so_d;
			clk_oe_q  <= clk_oe_d;
			data_oe_q <= data_oe_d;
			active_q  <= active_d;
			rise_q    <= rise_d;
			fall_q    <= fall_d;
			mosi_q    <= mosi_d;
			scl_q     <= scl_d;
			sda_q     <= sda_d;
			addr_q    <= addr_d;
			clk_drv_q  <= clk_drv_d;
			data_drv_q <= data_drv_d;
		end
	end

	assign i2c_mode_out        = mode_q;
	assign clk_pin_out         = clk_drv_q;
	assign clk_pin_oe_out      = clk_oe_q;
	assign data_pin_out        = data_drv_q;
	assign data_pin_oe_out     = data_oe_q;
	assign so_out              = so_q;
	assign spi_active_out      = active_q;
	assign spi_sck_rise_out    = rise_q;
	assign spi_sck_fall_out    = fall_q;
	assign spi_mosi_out        = mosi_q;
	assign i2c_scl_out         = scl_q;
	assign i2c_sda_out         = sda_q;
	assign slave_addr_bit0_out = addr_q;
	// Only ever pulls low; external pull-up gives the idle level
	assign int_n_out           = int_drv_q;
	assign int_oe_out          = int_oe_q;

endmodule : shps_top

// >>> verif/shps_properties.sv
// Checker for the host port pin multiplexer.
// Assumes it is bound to shps_top and sees only its ports.
`timescale 1ns/1ps
module shps_properties (
	input wire logic core_clk_in,         // Clock
	input wire logic resetn_in,           // Reset
	input wire logic i2c_mode_out,        // Mode
	input wire logic sel_pin_in,          // Select pin
	input wire logic data_pin_in,         // Data pin
	input wire logic core_rd_data_in,     // Read bit
	input wire logic core_i2c_sda_low_in, // Data pull
	input wire logic core_status_in,      // Status
	input wire logic core_int_clear_in,   // Clear
	input wire logic so_out,              // Serial out
	input wire logic spi_mosi_out,        // Data in
	input wire logic data_pin_oe_out,     // Data enable
	input wire logic slave_addr_bit0_out, // Address bit
	input wire logic int_oe_out,          // Interrupt
	input wire logic int_n_out,           // Interrupt level
	input wire logic spi_sck_rise_out     // Clock edge
);
	logic [1:0] age_q;
	logic [1:0] age_d;
	logic       ok;
	// Mode outputs settle two edges after reset, so checks wait three edges
	always_comb age_d = (age_q == 2'h3) ? age_q : age_q + 2'h1;
	always_ff @(posedge core_clk_in) age_q <= resetn_in ? age_d : 2'h0;
	assign ok = (age_q == 2'h3);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!resetn_in);
	chk_mode_hold: assert property (ok |-> $stable(i2c_mode_out))
		else $error("mode changed");
	chk_so_spi_only: assert property (ok |-> so_out ==
		$past(!i2c_mode_out && !sel_pin_in && core_rd_data_in)) else $error("so wrong");
	chk_mosi_follow: assert property (ok |-> spi_mosi_out ==
		$past(!i2c_mode_out && !sel_pin_in && data_pin_in)) else $error("mosi wrong");
	chk_sda_pull: assert property (ok |-> data_pin_oe_out ==
		$past(i2c_mode_out && core_i2c_sda_low_in)) else $error("sda enable wrong");
	chk_addr_bit: assert property (ok && $past(i2c_mode_out) |->
		slave_addr_bit0_out == $past(sel_pin_in)) else $error("address bit wrong");
	chk_int_flag: assert property (ok |-> int_oe_out ==
		($past(core_status_in) || $past(int_oe_out && !core_int_clear_in)))
		else $error("interrupt wrong");
	chk_int_drain: assert property (int_n_out == 1'b0)
		else $error("interrupt driven high");
	chk_idle_edges: assert property (ok && !i2c_mode_out && $past(sel_pin_in)
		&& $past(sel_pin_in, 2) && $past(sel_pin_in, 3) |-> !spi_sck_rise_out)
		else $error("edge while deselected");
endmodule : shps_properties

// >>> verif/shps_host_model.sv
// Host processor acting as SPI or I2C master on the shared pins.
// Assumes pull-ups on the open-drain lines; the device only pulls low.
`timescale 1ns/1ps
module shps_host_model (
	input  wire logic clk_in,       // Bench clock
	input  wire logic run_in,       // Frame request
	input  wire logic i2c_in,       // Host protocol, 1 = I2C
	input  wire logic addr_in,      // Address strap level
	input  wire logic clk_oe_in,    // Device pulls clock pin
	input  wire logic clk_drv_in,   // Device clock drive level
	input  wire logic data_oe_in,   // Device pulls data pin
	input  wire logic data_drv_in,  // Device data drive level
	output logic      clk_pin_out,  // Shared clock pin
	output logic      data_pin_out, // Shared data pin
	output logic      sel_pin_out   // Shared select pin
);
	logic        sck_q = 1'b0;
	logic        sd_q  = 1'b0;
	logic        cs_q  = 1'b1;
	integer      seed  = 81;
	logic [31:0] r;
	always @(posedge clk_in) begin
		r = $random(seed);
		if (i2c_in) begin
			cs_q  <= addr_in;
			sck_q <= r[0];
			sd_q  <= r[1];
		end else begin
			cs_q  <= !run_in;
			// Clock runs free while deselected, which the device must ignore
			sck_q <= run_in ? !sck_q : r[0];
			// Released data line must not hold its last value
			sd_q  <= run_in ? r[1] : !sd_q;
		end
	end
	// Wired-AND of host and device on the open-drain lines
	assign clk_pin_out  = sck_q & (clk_oe_in ? clk_drv_in : 1'b1);
	assign data_pin_out = sd_q & (data_oe_in ? data_drv_in : 1'b1);
	assign sel_pin_out  = cs_q;
endmodule : shps_host_model

// >>> verif/tb.sv
// Self-checking bench for the host port pin multiplexer.
// Assumes shps_host_model drives the shared pins.
`timescale 1ns/1ps
module tb;
	import shps_pkg::*;
	logic clk = 1'b0, rstn = 1'b0, strap = 1'b0, run = 1'b0, addr = 1'b0, em = 1'b0;
	logic rd = 1'b0, scl_lo = 1'b0, sda_lo = 1'b0, st = 1'b0, clr = 1'b0, live = 1'b0;
	logic c_pin, d_pin, s_pin, mode, c_oe, d_oe, so, mosi, ioe, ab;
	logic c_drv, d_drv, i_drv, act, rise, fall, scl, sda, c_prev = 1'b0;
	logic [13:0] exp_q = 14'h0;
	logic [13:0] seen;
	integer n_fail = 0, total_checks = 0, seed = 81;
	always #50 clk = ~clk;
	shps_top uut (.core_clk_in(clk), .resetn_in(rstn), .i2c_sel_in(strap),
		.clk_pin_in(c_pin), .data_pin_in(d_pin), .sel_pin_in(s_pin), .core_rd_data_in(rd),
		.core_i2c_scl_low_in(scl_lo), .core_i2c_sda_low_in(sda_lo), .core_status_in(st),
		.core_int_clear_in(clr), .i2c_mode_out(mode), .clk_pin_out(c_drv),
		.clk_pin_oe_out(c_oe), .data_pin_out(d_drv), .data_pin_oe_out(d_oe), .so_out(so),
		.spi_active_out(act), .spi_sck_rise_out(rise), .spi_sck_fall_out(fall),
		.spi_mosi_out(mosi), .i2c_scl_out(scl), .i2c_sda_out(sda), .slave_addr_bit0_out(ab),
		.int_n_out(i_drv), .int_oe_out(ioe));
	shps_host_model host (.clk_in(clk), .run_in(run), .i2c_in(em), .addr_in(addr),
		.clk_oe_in(c_oe), .clk_drv_in(c_drv), .data_oe_in(d_oe), .data_drv_in(d_drv),
		.clk_pin_out(c_pin), .data_pin_out(d_pin), .sel_pin_out(s_pin));
	// Order: drive levels, frame, clock edges, line levels, serial out, data in,
	// data pull, clock pull, interrupt, address bit
	assign seen = {c_drv, d_drv, i_drv, act, rise, fall, scl, sda, so, mosi, d_oe, c_oe, ioe, ab};
	function automatic logic [13:0] exp_fn(input logic [13:0] p);
		logic sel;
		sel = !em & !s_pin;
		return {3'h0, sel, sel & c_pin & !c_prev, sel & !c_pin & c_prev,
			em ? c_pin : 1'b1, em ? d_pin : 1'b1, sel & rd, sel & d_pin, em & sda_lo,
			em & scl_lo, st | (p[1] & !clr), em ? s_pin : p[0]};
	endfunction : exp_fn
	task automatic check(input string what, input logic [13:0] e, input logic [13:0] a);
		total_checks++;
		if (a !== e) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, e, a);
		end
	endtask : check
	always @(negedge clk) begin
		if (live) check("pins", exp_q, seen);
		exp_q = rstn ? exp_fn(exp_q) : 14'h0;
		c_prev = c_pin;
	end
	task automatic run_test(input string name, input logic m);
		logic [31:0] r;
		live = 1'b0;
		rstn <= 1'b0;
		strap <= m;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		em <= m;
		repeat (3) @(posedge clk);
		live = 1'b1;
		for (int i = 0; i < 400; i++) begin
			@(posedge clk);
			r = $random(seed);
			run <= (i % 16) < 11;
			rd <= r[0];
			scl_lo <= r[1];
			sda_lo <= r[2];
			addr <= r[3];
			// Status and clear together: set must win
			st <= (i == 5) | (r[4] & r[5]);
			clr <= (i == 5) | (r[6] & r[7]);
			if (i == 9) strap <= !m;
		end
		@(negedge clk);
		check("mode", {13'h0, m}, {13'h0, mode});
		$display("test %s done", name);
		@(posedge clk);
	endtask : run_test
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : end_of_test
	initial begin
		#500000;
		n_fail++;
		end_of_test();
	end
	initial begin
		run_test("spi", SHPS_SEL_SPI);
		run_test("i2c", SHPS_SEL_I2C);
		end_of_test();
	end
endmodule : tb
bind shps_top shps_properties chk (.*);
